// ==== verilog/rat_pkg.sv ====
`default_nettype none
package rat_pkg;
  // Timebase: the microsecond tick is derived from the 250 MHz system clock.
  localparam int unsigned CLK_PERIOD_PS = 4000;
  localparam int unsigned US_PS = 1000000;
  localparam int unsigned CYC_PER_US = US_PS / CLK_PERIOD_PS;
  localparam logic [7:0] CYC_PER_US_M1 = 8'(CYC_PER_US - 1);
  localparam logic [8:0] US_CNT_MAX = 9'h1FF;

  // Register addresses on the serial register port.
  localparam logic [4:0] ADDR_SEN_START = 5'h08;
  localparam logic [4:0] ADDR_SEN_WIDTH = 5'h09;
  localparam logic [4:0] ADDR_ANT_START = 5'h0A;
  localparam logic [4:0] ADDR_SLOT_START = 5'h0B;
  localparam logic [4:0] ADDR_PULSE_START = 5'h0C;
  localparam logic [4:0] ADDR_SIGNAL_STRENGTH_RESULT_POS = 5'h0D;
  localparam logic [4:0] ADDR_SIGNAL_STRENGTH_RESULT_RESULT = 5'h12;
  localparam logic [4:0] ADDR_AMP_POWER = 5'h18;
  localparam logic [4:0] ADDR_ENABLE = 5'h19;
  localparam logic [4:0] ADDR_BIAS_START = 5'h1A;
  localparam logic [4:0] ADDR_TABLE_DATA = 5'h1C;
  localparam int unsigned TABLE_PTR_RST_BIT = 6;

  // Values after reset.
  localparam logic [7:0] RST_SEN_START = 8'h0C;
  localparam logic [7:0] RST_SEN_WIDTH = 8'hC8;
  localparam logic [7:0] RST_ANT_START = 8'h64;
  localparam logic [7:0] RST_SLOT_START = 8'h0A;
  localparam logic [7:0] RST_PULSE_START = 8'h02;
  localparam logic [7:0] RST_SIGNAL_STRENGTH_RESULT_POS = 8'h64;
  localparam logic [7:0] RST_SIGNAL_STRENGTH_RESULT_RESULT = 8'h00;
  localparam logic [7:0] RST_AMP_POWER = 8'h00;
  localparam logic [7:0] RST_BIAS_START = 8'h64;

  // Least distance from the synthesizer-enable fall to the conversion start.
  localparam logic [8:0] SIGNAL_STRENGTH_RESULT_MIN_US = 9'h00A;

  // Modulation filter table.
  localparam int unsigned TABLE_DEPTH = 13;
  localparam logic [3:0] TABLE_LAST = 4'hC;
  localparam logic [0:12][7:0] TABLE_RESET = {
    8'h37, 8'h38, 8'h3A, 8'h3E, 8'h47, 8'h54, 8'h64,
    8'h74, 8'h81, 8'h89, 8'h8E, 8'h90, 8'h91
  };

  typedef struct packed {
    logic wr;
    logic rd;
    logic [4:0] addr;
    logic [7:0] wdata;
  } rat_req_t;

  typedef struct packed {
    logic synth_enable;
    logic antenna_switch_signal;
    logic slot_counter_signal;
    logic enable_pulse;
    logic modulation_bias_start;
    logic adc_start;
  } rat_strobes_t;
endpackage
`default_nettype wire

// ==== verilog/rat_regs.sv ====
`default_nettype none
module rat_regs (
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Register port from the serial engine
  input wire rat_pkg::rat_req_t req,
  output logic [7:0] rdata,
  output logic rvalid,
  // Packet framing from the baseband
  input wire logic packet_start,
  input wire logic packet_end,
  input wire logic rx_packet,
  // Signal-strength converter
  input wire logic adc_done,
  input wire logic [7:0] adc_data,
  // Radio strobes and power converter word
  output rat_pkg::rat_strobes_t strobes,
  output logic [7:0] amp_power_converter,
  // Filter table readout for the modulator
  input wire logic [3:0] filter_index,
  output logic [7:0] filter_value
);

  typedef enum {ST_IDLE, ST_SEN_WAIT, ST_SEN_ON, ST_SIGNAL_STRENGTH_RESULT_WAIT, ST_ADC_WAIT, ST_HOLD} rat_state_t;

  function automatic logic hit(input rat_pkg::rat_req_t r, input logic [4:0] a);
    hit = r.wr && (r.addr == a);
  endfunction

  function automatic logic [8:0] plus_one(input logic [7:0] v);
    plus_one = {1'b0, v} + 9'h001;
  endfunction

  logic [7:0] sen_start_q, sen_width_q, ant_start_q, slot_start_q;
  logic [7:0] pulse_start_q, signal_strength_result_pos_q, bias_start_q, signal_strength_result_q;
  localparam int unsigned TABLE_DEPTH_L = rat_pkg::TABLE_DEPTH;
  logic [7:0] table_q [TABLE_DEPTH_L];
  logic [3:0] ptr_q;
  logic [7:0] tick_div_q, pkt_div_q, step_div_q;
  logic [8:0] free_us_q, pkt_us_q, step_us_q;
  logic free_tick;
  logic rx_q;
  logic step_clr;
  logic [8:0] signal_strength_result_target;
  logic ptr_rst;
  rat_state_t state_q, state_d;

  // Timing registers are written only by the controller; no packet event touches them.
  always_ff @(posedge clock) begin
    if (srst) begin
      sen_start_q <= rat_pkg::RST_SEN_START;
      sen_width_q <= rat_pkg::RST_SEN_WIDTH;
      ant_start_q <= rat_pkg::RST_ANT_START;
      slot_start_q <= rat_pkg::RST_SLOT_START;
      pulse_start_q <= rat_pkg::RST_PULSE_START;
      signal_strength_result_pos_q <= rat_pkg::RST_SIGNAL_STRENGTH_RESULT_POS;
      bias_start_q <= rat_pkg::RST_BIAS_START;
    end else begin
      if (hit(req, rat_pkg::ADDR_SEN_START)) sen_start_q <= req.wdata;
      if (hit(req, rat_pkg::ADDR_SEN_WIDTH)) sen_width_q <= req.wdata;
      if (hit(req, rat_pkg::ADDR_ANT_START)) ant_start_q <= req.wdata;
      if (hit(req, rat_pkg::ADDR_SLOT_START)) slot_start_q <= req.wdata;
      if (hit(req, rat_pkg::ADDR_PULSE_START)) pulse_start_q <= req.wdata;
      if (hit(req, rat_pkg::ADDR_SIGNAL_STRENGTH_RESULT_POS)) signal_strength_result_pos_q <= req.wdata;
      if (hit(req, rat_pkg::ADDR_BIAS_START)) bias_start_q <= req.wdata;
    end
  end

  // The converter follows the written word on the next edge with no shadow copy.
  always_ff @(posedge clock) begin
    if (srst) begin
      amp_power_converter <= rat_pkg::RST_AMP_POWER;
    end else if (hit(req, rat_pkg::ADDR_AMP_POWER)) begin
      amp_power_converter <= req.wdata;
    end
  end

  // Filter table with a saturating write pointer.
  assign ptr_rst = hit(req, rat_pkg::ADDR_ENABLE) &&
                   req.wdata[rat_pkg::TABLE_PTR_RST_BIT];

  always_ff @(posedge clock) begin
    if (srst) begin
      ptr_q <= 4'h0;
    end else if (ptr_rst) begin
      ptr_q <= 4'h0;
    end else if (hit(req, rat_pkg::ADDR_TABLE_DATA) && ptr_q != rat_pkg::TABLE_LAST) begin
      ptr_q <= ptr_q + 4'h1;
    end
  end

  for (genvar i = 0; i < TABLE_DEPTH_L; i++) begin : g_table
    always_ff @(posedge clock) begin
      if (srst) begin
        table_q[i] <= rat_pkg::TABLE_RESET[i];
      end else if (hit(req, rat_pkg::ADDR_TABLE_DATA) && ptr_q == 4'(i)) begin
        table_q[i] <= req.wdata;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      filter_value <= rat_pkg::TABLE_RESET[0];
    end else if (filter_index > rat_pkg::TABLE_LAST) begin
      filter_value <= table_q[rat_pkg::TABLE_LAST];
    end else begin
      filter_value <= table_q[filter_index];
    end
  end

  // Read answer one cycle after the strobe; unmapped addresses read zero.
  always_ff @(posedge clock) begin
    if (srst) begin
      rdata <= 8'h00;
      rvalid <= 1'b0;
    end else begin
      rvalid <= req.rd;
      if (req.rd) begin
        case (req.addr)
          rat_pkg::ADDR_SEN_START: rdata <= sen_start_q;
          rat_pkg::ADDR_SEN_WIDTH: rdata <= sen_width_q;
          rat_pkg::ADDR_ANT_START: rdata <= ant_start_q;
          rat_pkg::ADDR_SLOT_START: rdata <= slot_start_q;
          rat_pkg::ADDR_PULSE_START: rdata <= pulse_start_q;
          rat_pkg::ADDR_SIGNAL_STRENGTH_RESULT_POS: rdata <= signal_strength_result_pos_q;
          rat_pkg::ADDR_SIGNAL_STRENGTH_RESULT_RESULT: rdata <= signal_strength_result_q;
          rat_pkg::ADDR_AMP_POWER: rdata <= amp_power_converter;
          rat_pkg::ADDR_BIAS_START: rdata <= bias_start_q;
          rat_pkg::ADDR_TABLE_DATA: rdata <= table_q[ptr_q];
          default: rdata <= 8'h00;
        endcase
      end
    end
  end

  // Free-running tick: delays counted on it land anywhere in a one-microsecond window.
  assign free_tick = (tick_div_q == rat_pkg::CYC_PER_US_M1);

  always_ff @(posedge clock) begin
    if (srst || free_tick) begin
      tick_div_q <= 8'h00;
    end else begin
      tick_div_q <= tick_div_q + 8'h01;
    end
  end

  always_ff @(posedge clock) begin
    if (srst || packet_start) begin
      free_us_q <= 9'h000;
    end else if (free_tick && free_us_q != rat_pkg::US_CNT_MAX) begin
      free_us_q <= free_us_q + 9'h001;
    end
  end

  // Packet-aligned counter gives the exact slot-counter timing.
  always_ff @(posedge clock) begin
    if (srst || packet_start) begin
      pkt_div_q <= 8'h00;
      pkt_us_q <= 9'h000;
    end else if (pkt_div_q == rat_pkg::CYC_PER_US_M1) begin
      pkt_div_q <= 8'h00;
      if (pkt_us_q != rat_pkg::US_CNT_MAX) pkt_us_q <= pkt_us_q + 9'h001;
    end else begin
      pkt_div_q <= pkt_div_q + 8'h01;
    end
  end

  // Step counter restarts at each synth-enable edge for exact widths.
  always_ff @(posedge clock) begin
    if (srst) begin
      step_div_q <= 8'h00;
      step_us_q <= 9'h000;
    end else if (step_clr) begin
      // Restarting at phase one ends a width on the edge that completes the count, not one later.
      step_div_q <= 8'h01;
      step_us_q <= 9'h000;
    end else if (step_div_q == rat_pkg::CYC_PER_US_M1) begin
      step_div_q <= 8'h00;
      if (step_us_q != rat_pkg::US_CNT_MAX) step_us_q <= step_us_q + 9'h001;
    end else begin
      step_div_q <= step_div_q + 8'h01;
    end
  end

  // A position below the settling gap is raised to it.
  assign signal_strength_result_target = ({1'b0, signal_strength_result_pos_q} < rat_pkg::SIGNAL_STRENGTH_RESULT_MIN_US) ?
                       rat_pkg::SIGNAL_STRENGTH_RESULT_MIN_US : {1'b0, signal_strength_result_pos_q};

  always_comb begin
    state_d = state_q;
    step_clr = 1'b0;
    if (packet_start) begin
      state_d = ST_SEN_WAIT;
    end else if (packet_end) begin
      state_d = ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: state_d = ST_IDLE;
        ST_SEN_WAIT: begin
          if (free_us_q == plus_one(sen_start_q)) begin
            state_d = ST_SEN_ON;
            step_clr = 1'b1;
          end
        end
        ST_SEN_ON: begin
          if (step_us_q == {1'b0, sen_width_q}) begin
            state_d = rx_q ? ST_SIGNAL_STRENGTH_RESULT_WAIT : ST_HOLD;
            step_clr = 1'b1;
          end
        end
        ST_SIGNAL_STRENGTH_RESULT_WAIT: begin
          if (step_us_q == signal_strength_result_target) state_d = ST_ADC_WAIT;
        end
        ST_ADC_WAIT: begin
          if (adc_done) state_d = ST_HOLD;
        end
        ST_HOLD: state_d = ST_HOLD;
        default: state_d = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state_q <= ST_IDLE;
      rx_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (packet_start) rx_q <= rx_packet;
    end
  end

  // Result is replaced only by a finished receive-packet conversion.
  always_ff @(posedge clock) begin
    if (srst) begin
      signal_strength_result_q <= rat_pkg::RST_SIGNAL_STRENGTH_RESULT_RESULT;
    end else if (state_q == ST_ADC_WAIT && adc_done && !packet_start && !packet_end) begin
      signal_strength_result_q <= adc_data;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      strobes <= '0;
    end else begin
      strobes.synth_enable <= (state_d == ST_SEN_ON);
      strobes.adc_start <= (state_q == ST_SIGNAL_STRENGTH_RESULT_WAIT) && (state_d == ST_ADC_WAIT);
      if (packet_start || packet_end || state_q == ST_IDLE) begin
        strobes.antenna_switch_signal <= 1'b0;
        strobes.slot_counter_signal <= 1'b0;
        strobes.enable_pulse <= 1'b0;
        strobes.modulation_bias_start <= 1'b0;
      end else begin
        // Starts compare with the free count; the slot counter uses the packet-aligned one.
        if (free_us_q == plus_one(ant_start_q)) strobes.antenna_switch_signal <= 1'b1;
        strobes.slot_counter_signal <= (pkt_us_q == plus_one(slot_start_q));
        strobes.enable_pulse <= (free_us_q == plus_one(pulse_start_q));
        if (free_us_q == plus_one(bias_start_q)) begin
          strobes.modulation_bias_start <= 1'b1;
        end
      end
    end
  end

  a_ptr_clear: assert property (@(posedge clock) disable iff (srst)
    ptr_rst |=> ptr_q == 4'h0) else $error("table pointer not cleared");
  a_ptr_advance: assert property (@(posedge clock) disable iff (srst)
    hit(req, rat_pkg::ADDR_TABLE_DATA) && !ptr_rst && ptr_q < rat_pkg::TABLE_LAST
    |=> ptr_q == $past(ptr_q) + 4'h1) else $error("table pointer did not advance");
  a_ptr_stick_last: assert property (@(posedge clock) disable iff (srst)
    hit(req, rat_pkg::ADDR_TABLE_DATA) && !ptr_rst && ptr_q == rat_pkg::TABLE_LAST
    |=> ptr_q == rat_pkg::TABLE_LAST && table_q[rat_pkg::TABLE_LAST] == $past(req.wdata))
    else $error("last table entry not overwritten");
  a_power_direct: assert property (@(posedge clock) disable iff (srst)
    hit(req, rat_pkg::ADDR_AMP_POWER) |=> amp_power_converter == $past(req.wdata))
    else $error("power word not applied at once");
  a_sen_start_delay: assert property (@(posedge clock) disable iff (srst)
    $rose(strobes.synth_enable) |-> $past(free_us_q) == plus_one(sen_start_q))
    else $error("synth enable rose at wrong time");
  a_timing_static: assert property (@(posedge clock) disable iff (srst)
    !hit(req, rat_pkg::ADDR_SEN_START) && !hit(req, rat_pkg::ADDR_SEN_WIDTH)
    |=> $stable(sen_start_q) && $stable(sen_width_q)) else $error("timing value moved");
  a_signal_strength_result_rx_only: assert property (@(posedge clock) disable iff (srst)
    strobes.adc_start |-> rx_q) else $error("conversion in transmit packet");
  a_signal_strength_result_gap: assert property (@(posedge clock) disable iff (srst)
    $rose(strobes.adc_start) |-> $past(step_us_q) >= rat_pkg::SIGNAL_STRENGTH_RESULT_MIN_US)
    else $error("conversion too soon after fall");
  a_slot_exact: assert property (@(posedge clock) disable iff (srst)
    $rose(strobes.slot_counter_signal) |-> $past(pkt_div_q) == 8'h00)
    else $error("slot counter start not aligned");
  a_signal_strength_result_capture: assert property (@(posedge clock) disable iff (srst)
    state_q == ST_ADC_WAIT && adc_done && !packet_start && !packet_end
    |=> signal_strength_result_q == $past(adc_data)) else $error("strength result not stored");

  // Each start strobe must rise on the microsecond that its own register selects.
  a_ant_start_delay: assert property (@(posedge clock) disable iff (srst)
    $rose(strobes.antenna_switch_signal) |-> $past(free_us_q) == plus_one(ant_start_q))
    else $error("antenna switch rose at wrong time");
  a_pulse_start_delay: assert property (@(posedge clock) disable iff (srst)
    $rose(strobes.enable_pulse) |-> $past(free_us_q) == plus_one(pulse_start_q))
    else $error("enable pulse at wrong time");
  a_bias_start_delay: assert property (@(posedge clock) disable iff (srst)
    $rose(strobes.modulation_bias_start) |-> $past(free_us_q) == plus_one(bias_start_q))
    else $error("bias start at wrong time");
  a_slot_start_delay: assert property (@(posedge clock) disable iff (srst)
    $rose(strobes.slot_counter_signal) |-> $past(pkt_us_q) == plus_one(slot_start_q))
    else $error("slot counter start at wrong time");
  a_sen_width_exact: assert property (@(posedge clock) disable iff (srst)
    $fell(strobes.synth_enable) && !$past(srst) && !$past(packet_start) && !$past(packet_end)
    |-> $past(step_us_q) == {1'b0, sen_width_q})
    else $error("synth enable width wrong");
  a_timing_static_more: assert property (@(posedge clock) disable iff (srst)
    !hit(req, rat_pkg::ADDR_ANT_START) && !hit(req, rat_pkg::ADDR_SIGNAL_STRENGTH_RESULT_POS)
    |=> $stable(ant_start_q) && $stable(signal_strength_result_pos_q)) else $error("timing value moved");
  a_signal_strength_result_tx_hold: assert property (@(posedge clock) disable iff (srst)
    !rx_q |=> $stable(signal_strength_result_q)) else $error("strength result moved in transmit packet");
  a_adc_one_pulse: assert property (@(posedge clock) disable iff (srst)
    strobes.adc_start |=> !strobes.adc_start) else $error("conversion start too long");
  a_table_write: assert property (@(posedge clock) disable iff (srst)
    hit(req, rat_pkg::ADDR_TABLE_DATA) |=> table_q[$past(ptr_q)] == $past(req.wdata))
    else $error("table entry not written");

endmodule
`default_nettype wire

// ==== verif/rat_conv_model.sv ====
`default_nettype none
module rat_conv_model #(
  parameter int LAT = 40,
  parameter logic [7:0] LEVEL = 8'h5C
) (
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Converter handshake
  input wire logic start,
  output logic done,
  output logic [7:0] data
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt = 0;
  initial done = 1'b0;
  initial data = 8'h00;
  // Outside the answer cycle the data lines toggle, so after the first answer a stale sample matches on every second cycle.
  always @(posedge clock) begin
    if (srst)
      cnt <= 0;
    else if (start)
      cnt <= LAT;
    else if (cnt != 0)
      cnt <= cnt - 1;
    done <= (cnt == 1) && !srst;
    data <= (cnt == 1) ? LEVEL : ~data;
  end
endmodule
`default_nettype wire

// ==== verif/rat_regs_tb.sv ====
`default_nettype none
module rat_regs_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock = 1'b0;
  logic srst = 1'b1;
  rat_pkg::rat_req_t req = '0;
  logic packet_start = 1'b0;
  logic packet_end = 1'b0;
  logic rx_packet = 1'b0;
  logic [3:0] filter_index = 4'h0;
  logic adc_done;
  logic rvalid;
  logic [7:0] adc_data;
  logic [7:0] rdata;
  logic [7:0] amp_power_converter;
  logic [7:0] filter_value;
  rat_pkg::rat_strobes_t strobes;
  rat_pkg::rat_strobes_t sp = '0;
  int miscompares = 0;
  int tests_run = 0;
  int cyc = 0;
  int ts = 0;
  int se_f = 0;
  int n_adc = 0;
  int rise [6];
  logic [4:0] ra [9] = '{5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h12, 5'h18, 5'h1A};
  logic [7:0] rv [9] = '{8'h0C, 8'hC8, 8'h64, 8'h0A, 8'h02, 8'h64, 8'h00, 8'h00, 8'h64};
  logic [7:0] wv [9] = '{8'h02, 8'h03, 8'h04, 8'h03, 8'h02, 8'h0C, 8'hFF, 8'hA5, 8'h06};
  logic [7:0] tr [13] = '{8'h37, 8'h38, 8'h3A, 8'h3E, 8'h47, 8'h54, 8'h64,
    8'h74, 8'h81, 8'h89, 8'h8E, 8'h90, 8'h91};

  rat_regs rat_regs_i (
    .clock(clock),
    .srst(srst),
    .req(req),
    .rdata(rdata),
    .rvalid(rvalid),
    .packet_start(packet_start),
    .packet_end(packet_end),
    .rx_packet(rx_packet),
    .adc_done(adc_done),
    .adc_data(adc_data),
    .strobes(strobes),
    .amp_power_converter(amp_power_converter),
    .filter_index(filter_index),
    .filter_value(filter_value)
  );

  rat_conv_model rat_conv_model_i (
    .clock(clock),
    .srst(srst),
    .start(strobes.adc_start),
    .done(adc_done),
    .data(adc_data)
  );

  initial forever #2 clock = ~clock;

  // Edge times are stored as the edge that launched each strobe change.
  always @(posedge clock) begin
    cyc <= cyc + 1;
    sp <= strobes;
    if (packet_start)
      ts <= cyc;
    for (int b = 0; b < 6; b++)
      if (strobes[b] & ~sp[b])
        rise[b] <= cyc - 1;
    if (~strobes.synth_enable & sp.synth_enable)
      se_f <= cyc - 1;
    if (strobes.adc_start & ~sp.adc_start)
      n_adc <= n_adc + 1;
  end

  task chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task rng(input int v, input int lo, input int hi);
    tests_run++;
    if (v < lo || v > hi) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h to %h", $time, v, lo, hi);
    end
  endtask

  task wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clock);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clock);
    req <= '0;
  endtask

  task rd(input logic [4:0] a, input logic [7:0] exp);
    @(posedge clock);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clock);
    req <= '0;
    #1;
    chk({7'h00, rvalid}, 8'h01);
    chk(rdata, exp);
  endtask

  task tblchk(input int i, input logic [7:0] exp);
    @(posedge clock);
    filter_index <= 4'(i);
    @(posedge clock);
    @(posedge clock);
    #1;
    chk(filter_value, exp);
  endtask

  // The window of 24 us covers every delay programmed below.
  task pkt(input logic rx);
    @(posedge clock);
    packet_start <= 1'b1;
    rx_packet <= rx;
    @(posedge clock);
    packet_start <= 1'b0;
    repeat (6000) @(posedge clock);
    packet_end <= 1'b1;
    @(posedge clock);
    packet_end <= 1'b0;
  endtask

  task results;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge clock);
    srst <= 1'b0;
    for (int i = 0; i < 9; i++)
      rd(ra[i], rv[i]);
    for (int i = 0; i < 14; i++)
      tblchk(i, tr[i > 12 ? 12 : i]);
    wr(5'h18, 8'h5A);
    #1;
    chk(amp_power_converter, 8'h5A);
    for (int i = 0; i < 9; i++) begin
      wr(ra[i], wv[i]);
      rd(ra[i], i == 6 ? 8'h00 : wv[i]);
    end
    rd(5'h1F, 8'h00);
    wr(5'h19, 8'h40);
    for (int i = 0; i < 14; i++)
      wr(5'h1C, 8'(8'hA0 + i));
    rd(5'h1C, 8'hAD);
    for (int i = 0; i < 14; i++)
      tblchk(i, i < 12 ? 8'(8'hA0 + i) : 8'hAD);
    wr(5'h19, 8'h40);
    rd(5'h1C, 8'hA0);
    pkt(1'b1);
    rng(rise[5] - ts, 500, 751);
    rng(se_f - rise[5], 750, 750);
    rng(rise[4] - ts, 1000, 1251);
    rng(rise[3] - ts, 1000, 1001);
    rng(rise[2] - ts, 500, 751);
    rng(rise[1] - ts, 1500, 1751);
    rng(rise[0] - se_f, 3000, 3000);
    rd(5'h12, 8'h5C);
    pkt(1'b0);
    rng(n_adc, 1, 1);
    rd(5'h12, 8'h5C);
    for (int i = 0; i < 9; i++)
      if (i != 6)
        rd(ra[i], wv[i]);
    results();
  end
endmodule
`default_nettype wire
